// >>> rtl/tdm_port_consts.vh
// Constants for the multiplexed command and audio serial port
`ifndef TDM_PORT_CONSTS_VH
`define TDM_PORT_CONSTS_VH

// Packet layout
`define TDM_PKT_LAST 5'd31
`define TDM_BIT_ID_ASSIGN 31
`define TDM_BIT_EXT_CMD 30
`define TDM_BIT_CHAIN_SEL 29
`define TDM_DEVID_HI 28
`define TDM_DEVID_LO 24
`define TDM_BIT_READ 23
`define TDM_REGNUM_HI 22
`define TDM_REGNUM_LO 16
`define TDM_SAMPLE_HI 31
`define TDM_SAMPLE_LO 8

// Device ID values
`define TDM_ID_BROADCAST 5'h1f
`define TDM_ID_NONE 5'h00
`define TDM_ID_MAX 5'd30
`define TDM_STROBE_PULSE 3'd2

// Read window in bit positions after the frame's shift counter
`define TDM_RD_ARM 5'd14
`define TDM_RD_LOAD 5'd15
`define TDM_RD_FIRST 5'd16
`define TDM_RD_LAST 5'd23

// Device register numbers
`define TDM_REG_FIRST 7'd16
`define TDM_REG_LAST_RW 7'd20
`define TDM_REG_LAST 7'd22
`define TDM_REG_DEVID 7'd23
`define TDM_REG_OUTCTL_IDX 3
`define TDM_OUTCTL_BIT 4
`define TDM_REG_RESET 8'h00

// AXI4-Lite map, byte addresses
`define TDM_AXI_CONTROL 5'h00
`define TDM_AXI_STATUS 5'h04
`define TDM_AXI_LEFT 5'h08
`define TDM_AXI_RIGHT 5'h0c
`define TDM_AXI_OUTCTL 5'h10
`define TDM_CONTROL_RESET 1'b1
`define TDM_RESP_OKAY 2'b00
`define TDM_RESP_DECERR 2'b11

`endif

// >>> rtl/tdm_pin_sync.v
// Two-stage synchroniser for link pins
`timescale 1ns/1ps
`default_nettype none
module tdm_pin_sync #(
	parameter WIDTH = 4
) (
	input wire clock,
	input wire rst,
	input wire clockEnable,
	input wire [WIDTH-1:0] pinIn,
	output reg [WIDTH-1:0] pinSync
);
	reg [WIDTH-1:0] stage1_r;

	// First stage feeds only the second
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			stage1_r <= {WIDTH{1'b0}};
			pinSync <= {WIDTH{1'b0}};
		end else if (clockEnable) begin
			stage1_r <= pinIn;
			pinSync <= stage1_r;
		end
	end
endmodule
`default_nettype wire

// >>> rtl/tdm_command_audio_port.v
// Multiplexed command and audio serial port with AXI4-Lite status
//
// Behaviour
// - Every packet is 32 bits; its low byte carries no meaning.
// - Packets shift most significant bit first.
// - Bit 30 high adds an extended packet; such frames carry no audio.
// - Two audio channels take part unless the output control bit in register 19 is set.
// - Bit 31 high makes the frame an ID-assignment frame; other bits ignored.
// - Bit 29 selects chain; this input-chain device acts only when it is low.
// - Bits 28:24 give the device ID; chain top is ID 1, then 2, 3.
// - At most 30 IDs are valid per chain.
// - Write with ID 0x1F is a broadcast accepted by every device.
// - ID 0x00 selects no device.
// - Bit 23 high requests a register read, low a write.
// - Bits 22:16 hold the register number, bits 15:8 the data.
// - Read replies never drive the unused low byte.
// - Extended packet decodes like the command, bit 31 reserved.
// - Register 23 reports the acquired device ID.
// - Read data shifts out during the data phase of the command.
// - Input sampled on bit clock rise; output launched on its fall.
// - Output driver enables one bit clock before the first data bit.
// - Chain output is high during the last owned audio channel.
// - Device with the register 19 output control bit set passes chain input to chain output outside ID frames.
// - Two frames with a two-bit-clock strobe pulse enter multiplexed mode.
// - In ID frames the device counts bit clocks and watches chain input.
`timescale 1ns/1ps
`default_nettype none
`include "tdm_port_consts.vh"
module tdm_command_audio_port #(
	parameter SAMPLE_W = 24
) (
	input wire clock,
	input wire rst,
	input wire clockEnable,
	input wire [4:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [4:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire bit_clock,
	input wire frame_strobe,
	input wire serial_in,
	input wire chain_in,
	output reg serialOut,
	output reg serialOutEn,
	output reg chainOut,
	output reg [SAMPLE_W-1:0] leftSample,
	output reg [SAMPLE_W-1:0] rightSample,
	output reg sampleValid,
	output reg muxMode
);
	wire [3:0] pinSync;
	wire bckS = pinSync[3];
	wire strobeS = pinSync[2];
	wire dataS = pinSync[1];
	wire chainS = pinSync[0];

	reg bckPrev_r;
	reg portEnable_r;
	reg prevStrobe_r;
	reg [2:0] strobeWidth_r;
	reg [1:0] goodFrames_r;
	reg [31:0] shift_r;
	reg [4:0] bitIdx_r;
	reg [4:0] pktIdx_r;
	reg frameOn_r;
	reg idFrame_r;
	reg extPending_r;
	reg audioOk_r;
	reg [4:0] devId_r;
	reg [4:0] idCount_r;
	reg idSeen_r;
	reg [1:0] slot_r;
	reg [SAMPLE_W-1:0] leftHold_r;
	reg readArm_r;
	reg [7:0] outShift_r;
	reg [7:0] devReg_r [0:6];
	reg [4:0] awAddr_r;
	reg awHeld_r;
	reg [31:0] wData_r;
	reg [3:0] wStrb_r;
	reg wHeld_r;
	integer i;

	wire bckRise = bckS & ~bckPrev_r;
	wire bckFall = ~bckS & bckPrev_r;
	wire riseEn = bckRise & portEnable_r;
	wire fallEn = bckFall & portEnable_r;
	wire frameStart = strobeS & ~prevStrobe_r;
	wire [31:0] newBit = {shift_r[30:0], dataS};
	wire outDisable = devReg_r[`TDM_REG_OUTCTL_IDX][`TDM_OUTCTL_BIT];

	// Command selects this device
	function cmdSelected;
		input [4:0] ownId;
		input chainSel;
		input [4:0] cmdId;
		input isRead;
		begin
			cmdSelected = ~chainSel &
				(((ownId != `TDM_ID_NONE) && (cmdId == ownId)) ||
				((cmdId == `TDM_ID_BROADCAST) && ~isRead));
		end
	endfunction

	// Device register read value
	function [7:0] devRegRead;
		input [6:0] num;
		input [4:0] ownId;
		reg [6:0] off;
		begin
			off = num - `TDM_REG_FIRST;
			if (num == `TDM_REG_DEVID)
				devRegRead = {3'h0, ownId};
			else if (num >= `TDM_REG_FIRST && num <= `TDM_REG_LAST)
				devRegRead = devReg_r[off[2:0]];
			else
				devRegRead = 8'h00;
		end
	endfunction

	// Pin synchroniser
	tdm_pin_sync #(
		.WIDTH(4)
	) pinSyncInst (
		.clock(clock),
		.rst(rst),
		.clockEnable(clockEnable),
		.pinIn({bit_clock, frame_strobe, serial_in, chain_in}),
		.pinSync(pinSync)
	);

	// Bit clock edge finder
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			bckPrev_r <= 1'b0;
		end else if (clockEnable) begin
			bckPrev_r <= bckS;
		end
	end

	// Strobe width watch for mode entry
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			prevStrobe_r <= 1'b0;
			strobeWidth_r <= 3'h0;
			goodFrames_r <= 2'h0;
			muxMode <= 1'b0;
		end else if (clockEnable) begin
			if (!portEnable_r) begin
				goodFrames_r <= 2'h0;
				muxMode <= 1'b0;
			end else if (bckRise) begin
				prevStrobe_r <= strobeS;
				if (strobeS) begin
					if (!prevStrobe_r)
						strobeWidth_r <= 3'h1;
					else if (strobeWidth_r != 3'h7)
						strobeWidth_r <= strobeWidth_r + 3'h1;
				end else if (prevStrobe_r) begin
					if (strobeWidth_r == `TDM_STROBE_PULSE) begin
						if (goodFrames_r != 2'h2)
							goodFrames_r <= goodFrames_r + 2'h1;
						if (goodFrames_r != 2'h0)
							muxMode <= 1'b1;
					end else begin
						goodFrames_r <= 2'h0;
						muxMode <= 1'b0;
					end
				end
			end
		end
	end

	// Receive side on bit clock rise; register 19 also taken from the AXI write
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			shift_r <= 32'h0;
			bitIdx_r <= 5'h0;
			pktIdx_r <= 5'h0;
			frameOn_r <= 1'b0;
			idFrame_r <= 1'b0;
			extPending_r <= 1'b0;
			audioOk_r <= 1'b0;
			devId_r <= `TDM_ID_NONE;
			idCount_r <= 5'h0;
			idSeen_r <= 1'b0;
			slot_r <= 2'h0;
			leftHold_r <= {SAMPLE_W{1'b0}};
			leftSample <= {SAMPLE_W{1'b0}};
			rightSample <= {SAMPLE_W{1'b0}};
			sampleValid <= 1'b0;
			readArm_r <= 1'b0;
			for (i = 0; i < 7; i = i + 1)
				devReg_r[i] <= `TDM_REG_RESET;
		end else if (clockEnable) begin
			sampleValid <= 1'b0;
			if (s_axi_bvalid == 1'b0 && awHeld_r && wHeld_r && wStrb_r[0] &&
				awAddr_r == `TDM_AXI_OUTCTL)
				devReg_r[`TDM_REG_OUTCTL_IDX] <= wData_r[7:0];
			if (riseEn && frameStart) begin
				shift_r <= {31'h0, dataS};
				bitIdx_r <= 5'h1;
				pktIdx_r <= 5'h0;
				frameOn_r <= muxMode;
				idFrame_r <= 1'b0;
				extPending_r <= 1'b0;
				audioOk_r <= 1'b1;
				idCount_r <= 5'h0;
				slot_r <= 2'h0;
				readArm_r <= 1'b0;
			end else if (riseEn) begin
				shift_r <= newBit;
				bitIdx_r <= bitIdx_r + 5'h1;
				// ID assignment walk along the chain
				if (idFrame_r && frameOn_r) begin
					if (idCount_r != 5'h1f)
						idCount_r <= idCount_r + 5'h1;
					if (!idSeen_r && chainS) begin
						idSeen_r <= 1'b1;
						devId_r <= (idCount_r < `TDM_ID_MAX) ?
							idCount_r + 5'h1 : `TDM_ID_MAX;
					end
				end
				// Read arming once ID and direction are known
				if (frameOn_r && !idFrame_r && bitIdx_r == `TDM_RD_ARM &&
					(pktIdx_r == 5'h0 || extPending_r))
					readArm_r <= ~(pktIdx_r == 5'h0 && newBit[14]) & newBit[6] &
						cmdSelected(devId_r, newBit[12], newBit[11:7], 1'b1);
				if (bitIdx_r == `TDM_RD_LAST)
					readArm_r <= 1'b0;
				// Packet complete
				if (bitIdx_r == `TDM_PKT_LAST && frameOn_r && !idFrame_r) begin
					if (pktIdx_r != 5'h1f)
						pktIdx_r <= pktIdx_r + 5'h1;
					if (pktIdx_r == 5'h0 && newBit[`TDM_BIT_ID_ASSIGN]) begin
						idFrame_r <= 1'b1;
						idSeen_r <= 1'b0;
						audioOk_r <= 1'b0;
					end else if (pktIdx_r == 5'h0 || extPending_r) begin
						extPending_r <= newBit[`TDM_BIT_EXT_CMD];
						if (newBit[`TDM_BIT_EXT_CMD] || extPending_r)
							audioOk_r <= 1'b0;
						if (!newBit[`TDM_BIT_READ] && cmdSelected(devId_r,
							newBit[`TDM_BIT_CHAIN_SEL],
							newBit[`TDM_DEVID_HI:`TDM_DEVID_LO], 1'b0) &&
							newBit[`TDM_REGNUM_HI:`TDM_REGNUM_LO] >= `TDM_REG_FIRST &&
							newBit[`TDM_REGNUM_HI:`TDM_REGNUM_LO] <= `TDM_REG_LAST_RW)
							devReg_r[newBit[18:16] - 3'h0] <= newBit[15:8];
						if (slot_r == 2'h0 && chainS && !outDisable &&
							!newBit[`TDM_BIT_EXT_CMD] && !extPending_r)
							slot_r <= 2'h1;
					end else if (audioOk_r) begin
						// Audio packet: top 24 bits, low byte dropped
						if (slot_r == 2'h1) begin
							leftHold_r <= newBit[`TDM_SAMPLE_HI:`TDM_SAMPLE_LO];
							slot_r <= 2'h2;
						end else if (slot_r == 2'h2) begin
							leftSample <= leftHold_r;
							rightSample <= newBit[`TDM_SAMPLE_HI:`TDM_SAMPLE_LO];
							sampleValid <= 1'b1;
							slot_r <= 2'h3;
						end else if (slot_r == 2'h0 && chainS && !outDisable) begin
							slot_r <= 2'h1;
						end
					end
				end
			end
		end
	end

	// Transmit side on bit clock fall; read byte loaded on the rise
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			serialOut <= 1'b0;
			serialOutEn <= 1'b0;
			chainOut <= 1'b0;
			outShift_r <= 8'h0;
		end else if (clockEnable) begin
			if (riseEn && readArm_r && bitIdx_r == `TDM_RD_LOAD)
				outShift_r <= devRegRead(newBit[6:0], devId_r);
			if (fallEn) begin
				// Driver on from one bit ahead to the last data bit
				serialOutEn <= readArm_r && bitIdx_r >= `TDM_RD_LOAD &&
					bitIdx_r <= `TDM_RD_LAST;
				if (readArm_r && bitIdx_r >= `TDM_RD_FIRST &&
					bitIdx_r <= `TDM_RD_LAST) begin
					serialOut <= outShift_r[7];
					outShift_r <= {outShift_r[6:0], 1'b0};
				end else begin
					serialOut <= 1'b0;
				end
				// Chain output by frame kind
				if (idFrame_r && frameOn_r)
					chainOut <= idSeen_r;
				else if (outDisable)
					chainOut <= chainS;
				else
					chainOut <= frameOn_r && slot_r == 2'h2;
			end
		end
	end

	// AXI4-Lite write channels, address and data in either order
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `TDM_RESP_OKAY;
			awAddr_r <= 5'h0;
			awHeld_r <= 1'b0;
			wData_r <= 32'h0;
			wStrb_r <= 4'h0;
			wHeld_r <= 1'b0;
			portEnable_r <= `TDM_CONTROL_RESET;
		end else if (clockEnable) begin
			if (s_axi_awvalid && s_axi_awready) begin
				awAddr_r <= s_axi_awaddr;
				awHeld_r <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wData_r <= s_axi_wdata;
				wStrb_r <= s_axi_wstrb;
				wHeld_r <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (awHeld_r && wHeld_r && !s_axi_bvalid) begin
				s_axi_bvalid <= 1'b1;
				if (awAddr_r == `TDM_AXI_CONTROL) begin
					s_axi_bresp <= `TDM_RESP_OKAY;
					if (wStrb_r[0])
						portEnable_r <= wData_r[0];
				end else if (awAddr_r == `TDM_AXI_OUTCTL ||
					awAddr_r == `TDM_AXI_STATUS || awAddr_r == `TDM_AXI_LEFT ||
					awAddr_r == `TDM_AXI_RIGHT) begin
					s_axi_bresp <= `TDM_RESP_OKAY;
				end else begin
					s_axi_bresp <= `TDM_RESP_DECERR;
				end
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				awHeld_r <= 1'b0;
				wHeld_r <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// AXI4-Lite read channel
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `TDM_RESP_OKAY;
		end else if (clockEnable) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `TDM_RESP_OKAY;
				case (s_axi_araddr)
					`TDM_AXI_CONTROL: s_axi_rdata <= {31'h0, portEnable_r};
					`TDM_AXI_STATUS: s_axi_rdata <= {21'h0, idSeen_r, idFrame_r,
						muxMode, slot_r, 1'b0, devId_r};
					`TDM_AXI_LEFT: s_axi_rdata <= {{(32-SAMPLE_W){1'b0}}, leftSample};
					`TDM_AXI_RIGHT: s_axi_rdata <= {{(32-SAMPLE_W){1'b0}}, rightSample};
					`TDM_AXI_OUTCTL: s_axi_rdata <= {24'h0,
						devReg_r[`TDM_REG_OUTCTL_IDX]};
					default: begin
						s_axi_rdata <= 32'h0;
						s_axi_rresp <= `TDM_RESP_DECERR;
					end
				endcase
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// >>> sim/tdm_command_audio_port_asserts.sv
// Checker for the link pins of the audio port
`timescale 1ns/1ps
`default_nettype none
module tdm_port_checker (
	input wire logic clock,
	input wire logic rst,
	input wire logic bit_clock,
	input wire logic serialOut,
	input wire logic serialOutEn,
	input wire logic chainOut,
	input wire logic sampleValid,
	input wire logic muxMode
);
	logic [7:0] enLen_r;
	default clocking @(posedge clock);
	endclocking
	default disable iff (rst);
	// Clocks the read driver has stood on
	always @(posedge clock or posedge rst) begin
		if (rst)
			enLen_r <= 8'h00;
		else
			enLen_r <= serialOutEn ? enLen_r + 8'h01 : 8'h00;
	end
	// Pin timing and driver window
	AST_OE_MUX: assert property (serialOutEn |-> muxMode)
		else $error("driver on outside mode");
	AST_OE_FALL: assert property ($changed(serialOutEn) |-> !$past(bit_clock))
		else $error("enable moved off a fall");
	AST_DO_FALL: assert property (serialOutEn && $changed(serialOut) |-> !$past(bit_clock))
		else $error("data moved off a fall");
	AST_CO_FALL: assert property ($changed(chainOut) |-> !$past(bit_clock))
		else $error("chain moved off a fall");
	AST_OE_EARLY: assert property ($rose(serialOutEn) |-> !serialOut)
		else $error("early bit not zero");
	AST_OE_LEN: assert property ($fell(serialOutEn) |-> enLen_r > 8'd70 && enLen_r < 8'd74)
		else $error("driver window not nine bits");
	AST_SV_PULSE: assert property (sampleValid |=> !sampleValid)
		else $error("sample strobe too long");
	AST_SV_MUX: assert property (sampleValid |-> muxMode)
		else $error("sample outside mode");
	COV_READ: cover property ($rose(serialOutEn));
	COV_PAIR: cover property (sampleValid);
	COV_CHAIN: cover property ($rose(chainOut));
endmodule
bind tdm_command_audio_port tdm_port_checker chk (.clock, .rst, .bit_clock, .serialOut,
	.serialOutEn, .chainOut, .sampleValid, .muxMode);
`default_nettype wire

// >>> sim/tdm_host_model.sv
// Host model driving frames onto the multiplexed link
`timescale 1ns/1ps
`default_nettype none
module tdm_host_model (
	output logic bitClock,
	output logic frameStrobe,
	output logic serialIn,
	output logic chainIn,
	input wire logic serialOut,
	input wire logic serialOutEn,
	input wire logic chainOut
);
	logic [7:0] rdByte;
	logic [127:0] coLog;
	int enCnt;
	int enBad;
	// Idle pins
	initial begin
		bitClock = 1'b0;
		frameStrobe = 1'b0;
		serialIn = 1'b0;
		chainIn = 1'b0;
	end
	// One frame, chain input raised from bit chainAt on
	task automatic sendFrame(input logic [127:0] d, input int nb, input int chainAt);
		int i;
		enCnt = 0;
		enBad = 0;
		#13;
		for (i = 0; i < nb; i++) begin
			frameStrobe = (i < 2);
			serialIn = d[127-i];
			chainIn = (chainAt >= 0 && i >= chainAt);
			#200 bitClock = 1'b1;
			#200 bitClock = 1'b0;
			// Pins here still hold what the previous fall launched
			if (serialOutEn) begin
				enCnt++;
				if (i < 15 || i > 23)
					enBad++;
			end
			if (i >= 16 && i <= 23)
				rdByte[23-i] = serialOut;
			coLog[i] = chainOut;
		end
		// Clock stands still, data line flips
		frameStrobe = 1'b0;
		serialIn = ~serialIn;
		chainIn = 1'b0;
		#1000;
	endtask
endmodule
`default_nettype wire

// >>> sim/tdm_command_audio_port_tb.sv
// Self-checking bench for the multiplexed audio port
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) check((g), (e))
module tdm_command_audio_port_tb;
	logic clock, rst, clockEnable, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_rready;
	logic [4:0] s_axi_awaddr, s_axi_araddr, myId;
	logic [31:0] s_axi_wdata, rd, a1, a2;
	logic [3:0] s_axi_wstrb;
	logic [1:0] resp;
	logic [7:0] v, expV;
	wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire logic [1:0] s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	wire logic bitClock, frameStrobe, serialIn, chainIn, serialOut, serialOutEn, chainOut;
	wire logic sampleValid, muxMode;
	wire logic [23:0] leftSample, rightSample;
	int fails = 0, compares = 0, svCount = 0, i;
	tdm_command_audio_port DUT (.clock, .rst, .clockEnable, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bit_clock(bitClock),
		.frame_strobe(frameStrobe), .serial_in(serialIn), .chain_in(chainIn), .serialOut,
		.serialOutEn, .chainOut, .leftSample, .rightSample, .sampleValid, .muxMode);
	tdm_host_model host (.bitClock, .frameStrobe, .serialIn, .chainIn, .serialOut,
		.serialOutEn, .chainOut);
	// System clock
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	// Counts latched sample pairs
	always @(posedge clock) if (sampleValid === 1'b1) svCount++;
	task automatic summarize();
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic check(input logic [95:0] g, input logic [95:0] e);
		compares++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// Bus write, each channel released once taken
	task automatic axiWrite(input logic [4:0] a, input logic [31:0] d);
		int n;
		logic awTk, wTk, bTk;
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			// Settled values ahead of the taking edge
			@(negedge clock);
			awTk = s_axi_awvalid & s_axi_awready;
			wTk = s_axi_wvalid & s_axi_wready;
			bTk = s_axi_bvalid;
			resp = s_axi_bresp;
			@(posedge clock);
			if (awTk) s_axi_awvalid <= 1'b0;
			if (wTk) s_axi_wvalid <= 1'b0;
			if (bTk) break;
		end
		s_axi_bready <= 1'b0;
		if (n == 50) begin
			fails++;
			summarize();
		end
	endtask
	task automatic axiRead(input logic [4:0] a);
		int n;
		logic arTk, rTk;
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			// Settled values ahead of the taking edge
			@(negedge clock);
			arTk = s_axi_arvalid & s_axi_arready;
			rTk = s_axi_rvalid;
			rd = s_axi_rdata;
			resp = s_axi_rresp;
			@(posedge clock);
			if (arTk) s_axi_arvalid <= 1'b0;
			if (rTk) break;
		end
		s_axi_rready <= 1'b0;
		if (n == 50) begin
			fails++;
			summarize();
		end
	endtask
	// Command packet with a random unused low byte
	function automatic logic [31:0] cmd(input logic [2:0] top, input logic [4:0] id,
		input logic r, input logic [6:0] num, input logic [7:0] d);
		return {top, id, r, num, d, 8'($urandom)};
	endfunction
	// Serial read, checking the driver window and the byte
	task automatic rdChk(input logic [4:0] id, input logic [6:0] num, input logic [7:0] e);
		host.sendFrame({cmd(3'h0, id, 1'b1, num, 8'h00), 96'h0}, 32, -1);
		`CHK({host.enCnt, host.enBad, host.rdByte}, {32'd9, 32'd0, e});
	endtask
	// Main sequence
	initial begin
		{clockEnable, rst} = 2'b11;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 42'h0;
		s_axi_wstrb = 4'hf;
		i = $urandom(32'h607a);
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		#1;
		`CHK({s_axi_awready, s_axi_arready, s_axi_bvalid, serialOutEn, muxMode}, 5'b11000);
		axiRead(5'h00);
		`CHK(rd, 32'h1);
		axiRead(5'h14);
		`CHK({resp, rd}, 34'h300000000);
		axiWrite(5'h04, 32'hffffffff);
		axiRead(5'h04);
		`CHK({resp, rd[7], rd[4:0]}, 8'h0);
		host.sendFrame(128'h0, 32, -1);
		`CHK(muxMode, 1'b0);
		host.sendFrame(128'h0, 32, -1);
		`CHK(muxMode, 1'b1);
		host.sendFrame({cmd({1'b1, 2'($urandom)}, 5'($urandom), 1'b1, 7'd23, 8'h0), 96'h0}, 64, 61);
		`CHK({host.coLog[62], host.coLog[59], host.enCnt}, {2'b10, 32'd0});
		myId = 5'd30;
		axiRead(5'h04);
		`CHK(rd[4:0], myId);
		rdChk(myId, 7'd23, {3'h0, myId});
		expV = 8'h00;
		for (i = 0; i < 5; i++) begin
			v = 8'($urandom);
			host.sendFrame({cmd({2'b00, i == 3}, i == 1 ? 5'h1f : i == 2 ? 5'h00 : myId - (i == 4),
				1'b0, 7'd16, v), 96'h0}, 32, -1);
			if (i < 2)
				expV = v;
			rdChk(myId, 7'd16, expV);
		end
		host.sendFrame({cmd(3'h0, 5'h1f, 1'b1, 7'd16, 8'h00), 96'h0}, 32, -1);
		`CHK(host.enCnt, 0);
		v = 8'($urandom) & 8'hef;
		axiWrite(5'h10, {24'h0, v});
		rdChk(myId, 7'd19, v);
		a1 = {24'($urandom), 8'h00};
		a2 = {24'($urandom), 8'h00};
		host.sendFrame({cmd(3'h0, 5'h00, 1'b0, 7'd0, 8'h00), a1, a2, 32'h0}, 96, 31);
		`CHK({leftSample, rightSample, svCount}, {a1[31:8], a2[31:8], 32'd1});
		`CHK({host.coLog[80], host.coLog[48]}, 2'b10);
		v = 8'($urandom);
		expV = 8'($urandom);
		host.sendFrame({cmd(3'b010, myId, 1'b0, 7'd17, v),
			cmd({1'($urandom), 2'b00}, myId, 1'b0, 7'd18, expV), ~a1, 32'h0}, 128, 63);
		`CHK(svCount, 1);
		rdChk(myId, 7'd17, v);
		rdChk(myId, 7'd18, expV);
		axiWrite(5'h10, 32'h10);
		host.sendFrame({cmd(3'h0, 5'h00, 1'b0, 7'd0, 8'h00), a2, a1, 32'h0}, 96, 31);
		`CHK({svCount, host.coLog[48]}, {32'd1, 1'b1});
		summarize();
	end
endmodule
`default_nettype wire
